// ### logic/aes_switch.sv
// automatic emulation switch: decision window, commit and mode register
// Operation
// - auto selection only when setting nineteen on
// - classify host commands as native or impact
// - decide only in open window after idle
// - commit after more than 512 bytes
// - commit after reception gap over three seconds
// - commit when put offline before thresholds
// - store reset: auto off, native selected
// - enabling auto keeps the previous mode
// - power-up loads the stored mode
// - vendor driver forces extended command mode
// - high quality in emulation uses colour normal
// - busy release timing follows effective emulation
`timescale 1ns/1ps
module aes_switch #(
  parameter logic [31:0] IDLE_LIMIT = 32'(aes_pkg::IDLE_CYCLES),
  parameter logic [31:0] GAP_LIMIT  = 32'(aes_pkg::GAP_CYCLES)
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // host data
  input  wire aes_pkg::aes_byte_s rxByte,
  input  wire logic               pendingData,
  input  wire logic               offline,
  // configuration
  input  wire logic               autoSwitchOn,
  input  wire aes_pkg::aes_mode_e manualMode,
  input  wire aes_pkg::aes_mode_e storedMode,
  input  wire logic               storeReset,
  input  wire logic               vendorDriver,
  input  wire logic               hqRequest,
  // parallel port timing
  input  wire logic               ackDone,
  output logic                    busyRelease,
  // status
  output aes_pkg::aes_mode_e      activeMode,
  output aes_pkg::aes_mode_e      effectiveMode,
  output logic                    colourNormal,
  output logic                    autoEnabled,
  output aes_pkg::aes_state_e     state
);
  import aes_pkg::*;

  aes_cmd_s               cmd;
  aes_state_e             next_state;
  aes_mode_e              candidate;
  logic [BYTE_CNT_W-1:0]  byteCount;
  logic                   gapExpired;
  logic                   idleExpired;
  logic                   loadPending;
  logic                   storeHold;
  logic                   commitHit;
  logic                   commit;
  logic [BUSY_CNT_W-1:0]  busyCount;

  //////////////////////////////////////////////////////////////////////
  // command recognition and timers
  aes_cmd_classifier u_classifier (
    .core_clk (core_clk),
    .rst      (rst),
    .rxByte   (rxByte),
    .cmd      (cmd)
  );

  aes_gap_timer #(.LIMIT(GAP_LIMIT)) u_gap (
    .core_clk (core_clk),
    .rst      (rst),
    .restart  (rxByte.valid),
    .expired  (gapExpired)
  );

  aes_gap_timer #(.LIMIT(IDLE_LIMIT)) u_idle (
    .core_clk (core_clk),
    .rst      (rst),
    .restart  (rxByte.valid),
    .expired  (idleExpired)
  );

  //////////////////////////////////////////////////////////////////////
  // store reset holds auto off until the setting is cleared
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      storeHold <= 1'b0;
    end else if (storeReset) begin
      storeHold <= 1'b1;
    end else if (!autoSwitchOn) begin
      storeHold <= 1'b0;
    end
  end

  assign autoEnabled = autoSwitchOn && !storeHold;

  // power-up load happens on the first edge after release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      loadPending <= 1'b1;
    end else begin
      loadPending <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bytes since the window opened
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byteCount <= '0;
    end else if (next_state == AES_OPEN && state != AES_OPEN) begin
      byteCount <= '0;
    end else if (rxByte.valid && byteCount <= BYTE_CNT_W'(BYTE_LIMIT)) begin
      byteCount <= byteCount + BYTE_CNT_W'(1);
    end
  end

  // any of the three commit triggers
  always_comb begin
    commitHit = (byteCount > BYTE_CNT_W'(BYTE_LIMIT))
             || (gapExpired && byteCount != '0)
             || offline;
  end

  assign commit = (state == AES_DECIDED) && commitHit && autoEnabled;

  //////////////////////////////////////////////////////////////////////
  // window state machine
  always_comb begin
    next_state = state;
    case (state)
      AES_OPEN: begin
        if (!autoEnabled) begin
          next_state = AES_OPEN;
        end else if (cmd.seen) begin
          next_state = AES_DECIDED;
        end else if (commitHit) begin
          next_state = AES_LOCKED;
        end
      end
      AES_DECIDED: begin
        if (!autoEnabled) begin
          next_state = AES_OPEN;
        end else if (commitHit) begin
          next_state = AES_LOCKED;
        end
      end
      AES_LOCKED: begin
        if (!autoEnabled) begin
          next_state = AES_OPEN;
        end else if (idleExpired && !pendingData) begin
          next_state = AES_OPEN;
        end
      end
      default: next_state = AES_OPEN;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= AES_OPEN;
    end else if (storeReset) begin
      state <= AES_OPEN;
    end else begin
      state <= next_state;
    end
  end

  // candidate captured when a command is decided in the window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      candidate <= AES_NATIVE;
    end else if (state == AES_OPEN && cmd.seen) begin
      candidate <= cmd.cls;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // active emulation register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      activeMode <= AES_NATIVE;
    end else if (storeReset) begin
      activeMode <= AES_NATIVE;
    end else if (loadPending) begin
      activeMode <= (storedMode == AES_IMPACT) ? AES_IMPACT
                                               : AES_NATIVE;
    end else if (!autoEnabled) begin
      activeMode <= (manualMode == AES_IMPACT) ? AES_IMPACT
                                               : AES_NATIVE;
    end else if (commit) begin
      activeMode <= candidate;
    end
  end

  // driver override and colour processing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      effectiveMode <= AES_NATIVE;
      colourNormal  <= 1'b0;
    end else begin
      effectiveMode <= vendorDriver ? AES_VENDOR : activeMode;
      colourNormal  <= hqRequest && !vendorDriver;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // busy release delay after acknowledge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busyCount   <= '0;
      busyRelease <= 1'b0;
    end else begin
      busyRelease <= (busyCount == BUSY_CNT_W'(1));
      if (ackDone) begin
        busyCount <= (effectiveMode == AES_IMPACT)
                   ? BUSY_CNT_W'(IMPACT_BUSY_CYC)
                   : BUSY_CNT_W'(NATIVE_BUSY_CYC);
      end else if (busyCount != '0) begin
        busyCount <= busyCount - BUSY_CNT_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  a_auto_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    !autoEnabled && !loadPending && !storeReset |=>
      activeMode == $past(manualMode == AES_IMPACT ? AES_IMPACT : AES_NATIVE))
    else $error("manual mode not followed");

  a_cmd_decide: assert property (
    @(posedge core_clk) disable iff (rst)
    state == AES_OPEN && autoEnabled && cmd.seen && !storeReset |=>
      state == AES_DECIDED && candidate == $past(cmd.cls))
    else $error("command not decided");

  a_window_reopen: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(state == AES_OPEN) |->
      $past(!autoEnabled || storeReset || (idleExpired && !pendingData)))
    else $error("window reopened early");

  a_byte_commit: assert property (
    @(posedge core_clk) disable iff (rst)
    state == AES_DECIDED && autoEnabled && !storeReset &&
    byteCount > BYTE_CNT_W'(BYTE_LIMIT) |=> state == AES_LOCKED)
    else $error("byte limit did not commit");

  a_byte_saturate: assert property (
    @(posedge core_clk) disable iff (rst)
    byteCount <= BYTE_CNT_W'(BYTE_LIMIT + 1))
    else $error("byte count ran past the limit");

  a_gap_commit: assert property (
    @(posedge core_clk) disable iff (rst)
    state == AES_DECIDED && autoEnabled && !storeReset && gapExpired &&
    byteCount != '0 |=> state == AES_LOCKED)
    else $error("gap did not commit");

  a_offline_commit: assert property (
    @(posedge core_clk) disable iff (rst)
    commit && !storeReset && !loadPending |=>
      activeMode == $past(candidate) && state == AES_LOCKED)
    else $error("commit not taken");

  a_store_reset: assert property (
    @(posedge core_clk) disable iff (rst)
    storeReset |=>
      activeMode == AES_NATIVE && !autoEnabled && state == AES_OPEN)
    else $error("store reset not applied");

  a_keep_mode: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(autoEnabled) && !storeReset && !loadPending |=>
      $stable(activeMode))
    else $error("mode changed on enable");

  a_power_load: assert property (
    @(posedge core_clk) disable iff (rst)
    loadPending && !storeReset |=>
      activeMode == $past(storedMode == AES_IMPACT ? AES_IMPACT : AES_NATIVE))
    else $error("stored mode not loaded");

  a_vendor_force: assert property (
    @(posedge core_clk) disable iff (rst)
    vendorDriver |=> effectiveMode == AES_VENDOR)
    else $error("vendor mode not forced");

  a_colour_normal: assert property (
    @(posedge core_clk) disable iff (rst)
    hqRequest && !vendorDriver |=> colourNormal)
    else $error("colour normal not selected");

  a_mode_cause: assert property (
    @(posedge core_clk) disable iff (rst)
    !$stable(activeMode) |->
      $past(commit || loadPending || storeReset || !autoEnabled))
    else $error("mode changed without cause");

  a_locked_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    state == AES_LOCKED && autoEnabled && !storeReset && !loadPending |=>
      $stable(activeMode))
    else $error("mode moved while locked");

  a_busy_timing: assert property (
    @(posedge core_clk) disable iff (rst)
    ackDone && effectiveMode == AES_IMPACT ##1 !ackDone [*8] |->
      busyCount == BUSY_CNT_W'(IMPACT_BUSY_CYC - 7))
    else $error("impact busy delay wrong");

  a_native_busy: assert property (
    @(posedge core_clk) disable iff (rst)
    ackDone && effectiveMode != AES_IMPACT |=>
      busyCount == BUSY_CNT_W'(NATIVE_BUSY_CYC))
    else $error("native busy delay wrong");

  a_busy_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    busyRelease |=> !busyRelease)
    else $error("busy release longer than one cycle");
endmodule

// ### logic/aes_pkg.sv
// shared constants and types for the automatic emulation switch
package aes_pkg;
  // clock rate and time figures
  localparam longint unsigned CLK_HZ        = 125_000_000;
  localparam longint unsigned IDLE_TIME_S   = 10;
  localparam longint unsigned GAP_TIME_S    = 3;
  localparam longint unsigned IDLE_CYCLES   = IDLE_TIME_S * CLK_HZ;
  localparam longint unsigned GAP_CYCLES    = GAP_TIME_S * CLK_HZ;
  // busy release delays after acknowledge, per emulation
  localparam int unsigned     CLK_PERIOD_NS = 8;
  localparam int unsigned     NATIVE_BUSY_NS = 1000;
  localparam int unsigned     IMPACT_BUSY_NS = 2000;
  localparam int unsigned     NATIVE_BUSY_CYC =
    (NATIVE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned     IMPACT_BUSY_CYC =
    (IMPACT_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned     BUSY_CNT_W    = 10;
  // byte threshold for commit
  localparam int unsigned     BYTE_LIMIT    = 512;
  localparam int unsigned     BYTE_CNT_W    = 10;
  localparam int unsigned     TIMER_W       = 32;
  // command recognition bytes
  localparam logic [7:0]      CMD_ESC       = 8'h1B;
  localparam logic [7:0]      CMD_NATIVE_A  = 8'h5B;
  localparam logic [7:0]      CMD_NATIVE_B  = 8'h28;
  localparam logic [7:0]      CMD_IMPACT_A  = 8'h2A;
  localparam logic [7:0]      CMD_IMPACT_B  = 8'h78;

  typedef enum logic [1:0] {
    AES_NATIVE = 2'b00,
    AES_IMPACT = 2'b01,
    AES_VENDOR = 2'b10
  } aes_mode_e;

  typedef enum logic [1:0] {
    AES_OPEN    = 2'b00,
    AES_DECIDED = 2'b01,
    AES_LOCKED  = 2'b10
  } aes_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } aes_byte_s;

  typedef struct packed {
    logic      seen;
    aes_mode_e cls;
  } aes_cmd_s;
endpackage

// ### logic/aes_gap_timer.sv
// counts cycles since the last restart and flags an overrun
`timescale 1ns/1ps
module aes_gap_timer #(
  parameter logic [31:0] LIMIT = 32'h0000_0010
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic restart,
  // status
  output logic      expired
);
  logic [31:0] count;

  // saturating count, expired once strictly over the limit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count   <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (restart) begin
      count   <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (count <= LIMIT) begin
      count   <= count + 32'h0000_0001;
      expired <= (count == LIMIT);
    end
  end
endmodule

// ### logic/aes_cmd_classifier.sv
// spots escape sequences and tells which command set they belong to
`timescale 1ns/1ps
module aes_cmd_classifier (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // host byte stream
  input  wire aes_pkg::aes_byte_s rxByte,
  // recognised command
  output aes_pkg::aes_cmd_s       cmd
);
  import aes_pkg::*;
  logic escSeen;

  // remember an escape so the next byte can be classified
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      escSeen <= 1'b0;
    end else if (rxByte.valid) begin
      escSeen <= (rxByte.data == CMD_ESC) && !escSeen;
    end
  end

  // one-cycle report with the class of the sequence
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd <= '{seen: 1'b0, cls: AES_NATIVE};
    end else begin
      cmd.seen <= 1'b0;
      if (rxByte.valid && escSeen) begin
        if (rxByte.data == CMD_NATIVE_A || rxByte.data == CMD_NATIVE_B) begin
          cmd <= '{seen: 1'b1, cls: AES_NATIVE};
        end else if (rxByte.data == CMD_IMPACT_A ||
                     rxByte.data == CMD_IMPACT_B) begin
          cmd <= '{seen: 1'b1, cls: AES_IMPACT};
        end
      end
    end
  end
endmodule

// ### verification/aes_host_model.sv
// host computer model that streams print bytes into the switch
`timescale 1ns/1ps
module aes_host_model (
  // clock
  input  wire logic   core_clk,
  // host byte stream
  output aes_pkg::aes_byte_s rxByte,
  output logic               pendingData
);
  import aes_pkg::*;

  // idle stream, nothing held in the printer
  initial begin
    rxByte      = '0;
    pendingData = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one byte, strobe high for one cycle, then a quiet cycle
  task automatic sendByte(input logic [7:0] b);
    @(negedge core_clk);
    rxByte = '{valid: 1'b1, data: b};
    @(negedge core_clk);
    rxByte = '{valid: 1'b0, data: ~b}; // stale data flipped, not held
  endtask

  // a run of filler bytes with no escape in them
  task automatic sendRun(input int n);
    for (int i = 0; i < n; i++) begin
      sendByte(8'h41);
    end
  endtask
endmodule

// ### verification/aes_switch_tb.sv
// self-checking bench for the automatic emulation switch
`timescale 1ns/1ps
module aes_switch_tb;
  import aes_pkg::*;

  localparam int IDLE_L = 200;
  localparam int GAP_L  = 60;

  logic       core_clk;
  logic       rst;
  aes_byte_s  rxByte;
  logic       pendingData;
  logic       offline;
  logic       autoSwitchOn;
  aes_mode_e  manualMode;
  aes_mode_e  storedMode;
  logic       storeReset;
  logic       vendorDriver;
  logic       hqRequest;
  logic       ackDone;
  logic       busyRelease;
  aes_mode_e  activeMode;
  aes_mode_e  effectiveMode;
  logic       colourNormal;
  logic       autoEnabled;
  aes_state_e state;
  int         bad_count;
  int         compares;

  ////////////////////////////////////////////////////////////////////////////
  // device and host
  aes_switch #(.IDLE_LIMIT(32'(IDLE_L)), .GAP_LIMIT(32'(GAP_L))) dut (
    .core_clk(core_clk), .rst(rst), .rxByte(rxByte),
    .pendingData(pendingData), .offline(offline),
    .autoSwitchOn(autoSwitchOn), .manualMode(manualMode),
    .storedMode(storedMode), .storeReset(storeReset),
    .vendorDriver(vendorDriver), .hqRequest(hqRequest),
    .ackDone(ackDone), .busyRelease(busyRelease),
    .activeMode(activeMode), .effectiveMode(effectiveMode),
    .colourNormal(colourNormal), .autoEnabled(autoEnabled),
    .state(state));

  aes_host_model host (
    .core_clk(core_clk), .rxByte(rxByte), .pendingData(pendingData));

  // clock at 8 ns
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // ack pulse, then edges counted until busy may drop
  task automatic busyTest(input int expCyc);
    int n;
    @(negedge core_clk);
    ackDone = 1'b1;
    @(negedge core_clk);
    ackDone = 1'b0;
    n = 0;
    while (busyRelease !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n, expCyc);
    $display("busy test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic testPowerUp;
    check(activeMode, AES_IMPACT);
    autoSwitchOn = 1'b0;
    manualMode   = AES_NATIVE;
    idle(3);
    check(activeMode, AES_NATIVE);
    check(state, AES_OPEN);
    autoSwitchOn = 1'b1;
    idle(2);
    check(activeMode, AES_NATIVE);
    $display("power-up test done");
  endtask

  task automatic testByteCommit;
    host.sendByte(CMD_ESC);
    host.sendByte(CMD_IMPACT_A);
    idle(3);
    check(state, AES_DECIDED);
    check(activeMode, AES_NATIVE);
    host.sendRun(510);
    idle(2);
    check(state, AES_DECIDED);
    host.sendByte(8'h41);
    idle(2);
    check(state, AES_LOCKED);
    check(activeMode, AES_IMPACT);
    // printer keeps the job, so the idle timer cannot reopen yet
    host.pendingData = 1'b1;
    $display("byte commit test done");
  endtask

  task automatic testIdleReopen;
    idle(IDLE_L + 20);
    check(state, AES_LOCKED);
    host.pendingData = 1'b0;
    idle(3);
    check(state, AES_OPEN);
    $display("idle test done");
  endtask

  task automatic testGapCommit;
    host.sendByte(CMD_ESC);
    host.sendByte(CMD_NATIVE_A);
    idle(GAP_L - 10);
    check(state, AES_DECIDED);
    idle(14);
    check(state, AES_LOCKED);
    check(activeMode, AES_NATIVE);
    idle(IDLE_L + 10);
    $display("gap test done");
  endtask

  task automatic testOffline;
    check(state, AES_OPEN);
    host.sendByte(CMD_ESC);
    host.sendByte(CMD_IMPACT_B);
    idle(3);
    offline = 1'b1;
    idle(3);
    check(state, AES_LOCKED);
    check(activeMode, AES_IMPACT);
    check(effectiveMode, AES_IMPACT);
    offline = 1'b0;
    // a command outside the open window is ignored
    host.sendByte(CMD_ESC);
    host.sendByte(CMD_NATIVE_A);
    idle(3);
    check(state, AES_LOCKED);
    check(activeMode, AES_IMPACT);
    $display("offline test done");
  endtask

  task automatic testVendor;
    vendorDriver = 1'b1;
    hqRequest    = 1'b1;
    idle(3);
    check(effectiveMode, AES_VENDOR);
    check(colourNormal, 1'b0);
    vendorDriver = 1'b0;
    idle(3);
    check(effectiveMode, AES_IMPACT);
    check(colourNormal, 1'b1);
    $display("vendor test done");
  endtask

  task automatic testStoreReset;
    @(negedge core_clk);
    storeReset = 1'b1;
    @(negedge core_clk);
    storeReset = 1'b0;
    idle(2);
    check(activeMode, AES_NATIVE);
    check(autoEnabled, 1'b0);
    $display("store reset test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence, inputs change at the falling edge
  initial begin
    bad_count = 0;
    compares = 0;
    rst = 1'b1;
    offline = 1'b0;
    autoSwitchOn = 1'b1;
    manualMode = AES_NATIVE;
    storedMode = AES_IMPACT;
    storeReset = 1'b0;
    vendorDriver = 1'b0;
    hqRequest = 1'b0;
    ackDone = 1'b0;
    idle(10);
    rst = 1'b0;
    idle(3);
    testPowerUp();
    busyTest(NATIVE_BUSY_CYC);
    testByteCommit();
    busyTest(IMPACT_BUSY_CYC);
    testIdleReopen();
    testGapCommit();
    testOffline();
    testVendor();
    testStoreReset();
    summarize();
  end

  // watchdog well beyond the expected run
  initial begin
    #(8 * 20000);
    bad_count++;
    summarize();
  end
endmodule
